/* iad_router.sv */
// inbound address disposition: decodes each inbound request to one target
// assumes requests and avalon-mm master synchronous to clk_sys_in (25 MHz)
//
// Summary of operation
// RL1: dos and low/medium memory go coherent
// RL2: video range, smm off, video off: abort
// RL3: video range, smm on, select zero: abort
// RL4: video enabled: non-coherent to pcie or hub
// RL5: bios segments with attribute 11: non-coherent
// RL6: isa hole: memory if clear, hub if set
// RL7: below top_of_low_memory minus smram size: coherent memory
// RL8: extended smram: abort if enabled, else memory
// RL9: legal window hit above top_of_low_memory: pcie port
// RL10: low mmio without window hit: hub abort
// RL11: config window accepted only when not blocked
// RL12: forwarded address passes through unchanged
// RL13: hub-origin aborts may end locally
// RL14: blocked config access treated as mmio
// RL15: unmatched addresses go subtractively to hub
// RL16: one disposition, resolved before issue
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module iad_router (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  input wire logic req_valid_in,
  input wire logic [iad_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic req_from_hub_in,
  output logic disp_valid_out,
  output iad_pkg::iad_disp_t disp_code_out,
  output logic [iad_pkg::ADDR_W-1:0] disp_addr_out,
  output logic [iad_pkg::PORT_W-1:0] disp_port_out
);
  import iad_pkg::*;

  // register state
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] top_of_low_memory, next_top_of_low_memory;
  logic [31:0] top_smram_segment, next_top_smram_segment;
  logic [31:0] esmm, next_esmm;
  logic [31:0] cfgb, next_cfgb;
  logic [ST_W-1:0] stat, next_stat;
  logic [ST_W-1:0] mask, next_mask;
  logic [31:0] cnt, next_cnt;
  logic [31:0] win_base [NWIN];
  logic [31:0] win_lim [NWIN];
  logic [31:0] next_win_base [NWIN];
  logic [31:0] next_win_lim [NWIN];
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;

  // decode state
  logic d_valid, next_d_valid;
  iad_disp_t d_code, next_d_code;
  logic [ADDR_W-1:0] d_addr, next_d_addr;
  logic [PORT_W-1:0] d_port, next_d_port;
  logic [ST_W-1:0] ev;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // window compares, one per window
  logic [MB_W-1:0] mb;
  logic [NWIN-1:0] win_hit;
  logic [PORT_W-1:0] win_port [NWIN];
  assign mb = req_addr_in[ADDR_W-1:MB_LSB];
  generate
    for (genvar w = 0; w < NWIN; w++) begin : g_win
      iad_window_match u_match (
        .mb_in(mb),
        .base_in(win_base[w]),
        .limit_in(win_lim[w]),
        .hit_out(win_hit[w]),
        .port_out(win_port[w])
      );
    end
  endgenerate

  // bus access: one wait cycle, answered on the second edge
  logic acc, wr_go, rd_go;
  logic [31:0] wmask;
  assign acc = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = acc && !ack;
  assign wr_go = avs_write_in && ack; // lands at the edge the master sees as answered
  assign rd_go = avs_read_in && !ack;
  assign wmask = merge(32'h0000_0000, avs_writedata_in, avs_byteenable_in);

  // next values of the register file
  always_comb begin
    next_ctrl = ctrl;
    next_top_of_low_memory = top_of_low_memory;
    next_top_smram_segment = top_smram_segment;
    next_esmm = esmm;
    next_cfgb = cfgb;
    next_mask = mask;
    next_win_base = win_base;
    next_win_lim = win_lim;
    next_ack = acc && !ack;
    next_rdata = rdata;
    next_cnt = d_valid ? cnt + 32'h0000_0001 : cnt;
    // set wins over the write-one clear
    next_stat = stat;
    if (wr_go && avs_address_in == REG_STAT) begin
      next_stat = stat & ~wmask[ST_W-1:0];
    end
    next_stat = next_stat | ev;
    if (wr_go) begin
      unique case (avs_address_in)
        REG_CTRL: next_ctrl = merge(ctrl, avs_writedata_in, avs_byteenable_in);
        REG_TOP_OF_LOW_MEMORY: next_top_of_low_memory = merge(top_of_low_memory, avs_writedata_in, avs_byteenable_in);
        REG_TOP_SMRAM_SEGMENT: next_top_smram_segment = merge(top_smram_segment, avs_writedata_in, avs_byteenable_in);
        REG_ESMM: next_esmm = merge(esmm, avs_writedata_in, avs_byteenable_in);
        REG_CFGB: next_cfgb = merge(cfgb, avs_writedata_in, avs_byteenable_in);
        REG_MASK: next_mask = avs_byteenable_in[0] ? avs_writedata_in[ST_W-1:0] : mask;
        default: begin
          for (int w = 0; w < NWIN; w++) begin
            if (avs_address_in == REG_WIN + 4'(2 * w)) begin
              next_win_base[w] = merge(win_base[w], avs_writedata_in, avs_byteenable_in);
            end
            if (avs_address_in == REG_WIN + 4'(2 * w + 1)) begin
              next_win_lim[w] = merge(win_lim[w], avs_writedata_in, avs_byteenable_in);
            end
          end
        end
      endcase
    end
    if (rd_go) begin
      // unmapped words read as zero
      next_rdata = 32'h0000_0000;
      unique case (avs_address_in)
        REG_CTRL: next_rdata = ctrl;
        REG_TOP_OF_LOW_MEMORY: next_rdata = top_of_low_memory;
        REG_TOP_SMRAM_SEGMENT: next_rdata = top_smram_segment;
        REG_ESMM: next_rdata = esmm;
        REG_CFGB: next_rdata = cfgb;
        REG_STAT: next_rdata = {28'h0000000, stat};
        REG_MASK: next_rdata = {28'h0000000, mask};
        REG_CNT: next_rdata = cnt;
        default: begin
          for (int w = 0; w < NWIN; w++) begin
            if (avs_address_in == REG_WIN + 4'(2 * w)) begin
              next_rdata = win_base[w];
            end
            if (avs_address_in == REG_WIN + 4'(2 * w + 1)) begin
              next_rdata = win_lim[w];
            end
          end
        end
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ctrl <= CTRL_RST;
      top_of_low_memory <= TOP_OF_LOW_MEMORY_RST;
      top_smram_segment <= TOP_SMRAM_SEGMENT_RST;
      esmm <= ESMM_RST;
      cfgb <= CFGB_RST;
      stat <= '0;
      mask <= '0;
      cnt <= 32'h0000_0000;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      for (int w = 0; w < NWIN; w++) begin
        win_base[w] <= WIN_RST;
        win_lim[w] <= WIN_RST;
      end
    end else begin
      ctrl <= next_ctrl;
      top_of_low_memory <= next_top_of_low_memory;
      top_smram_segment <= next_top_smram_segment;
      esmm <= next_esmm;
      cfgb <= next_cfgb;
      stat <= next_stat;
      mask <= next_mask;
      cnt <= next_cnt;
      ack <= next_ack;
      rdata <= next_rdata;
      win_base <= next_win_base;
      win_lim <= next_win_lim;
    end
  end

  assign avs_readdata_out = rdata;
  // level interrupt while any unmasked sticky bit stands
  assign irq_out = |(stat & mask);

  // programmable bounds in 1 MB granules
  logic [MB_W-1:0] top_of_low_memory_mb, top_smram_segment_mb, esmm_mb, cfg_mb, low_top, esmm_bot;
  logic in_cfg, in_esmm;
  assign top_of_low_memory_mb = top_of_low_memory[MB_W-1:0];
  assign top_smram_segment_mb = top_smram_segment[MB_W-1:0];
  assign esmm_mb = esmm[MB_W-1:0];
  assign cfg_mb = cfgb[MB_W-1:0];
  assign low_top = top_of_low_memory_mb - top_smram_segment_mb;
  assign esmm_bot = esmm_mb - top_smram_segment_mb;
  assign in_cfg = (mb >= cfg_mb) && ({1'b0, mb} < {1'b0, cfg_mb} + {1'b0, CFG_WIN_MB});
  assign in_esmm = (mb >= esmm_bot) && (mb < esmm_mb);

  // next disposition; the whole priority chain resolves in one cycle
  always_comb begin
    iad_disp_t c;
    logic [PORT_W-1:0] p;
    c = DSP_HUB;
    p = '0;
    ev = '0;
    if (req_addr_in < DOS_END) begin
      c = DSP_MEM_COH; // RL1
    end else if (req_addr_in < VGA_END) begin
      if (!ctrl[CTL_SMM_EN] && !ctrl[CTL_VGA_EN]) begin
        c = DSP_HUB_ABORT; // RL2
      end else if (ctrl[CTL_SMM_EN] && !ctrl[CTL_VGA_SMM_SEL]) begin
        c = DSP_HUB_ABORT; // RL3
      end else if (ctrl[CTL_VGA_EN]) begin
        // RL4
        c = ctrl[CTL_VGA_TO_PCIE] ? DSP_PCIE : DSP_HUB;
        p = ctrl[CTL_VGA_PORT_HI:CTL_VGA_PORT_LO];
      end else begin
        c = DSP_HUB_ABORT; // smram open but no video: never for inbound
      end
    end else if (req_addr_in < BIOS_END) begin
      if (ctrl[CTL_BIOS_HI:CTL_BIOS_LO] == BIOS_ATTR_RW) begin
        c = DSP_MEM_NC; // RL5
      end else begin
        c = DSP_HUB; // RL15
      end
    end else if (req_addr_in < LOWMED_END) begin
      c = DSP_MEM_COH; // RL1
    end else if (req_addr_in < HOLE_END) begin
      c = ctrl[CTL_HOLE_EN] ? DSP_HUB : DSP_MEM_COH; // RL6
    end else if (in_cfg && !ctrl[CTL_CFG_BLOCK]) begin
      c = DSP_CFG; // RL11
    end else if (mb < low_top) begin
      c = DSP_MEM_COH; // RL7
    end else if (in_esmm) begin
      c = ctrl[CTL_TOP_SMRAM_SEGMENT_EN] ? DSP_HUB_ABORT : DSP_MEM_COH; // RL8
    end else if (mb >= top_of_low_memory_mb && req_addr_in < MMIO_END) begin
      // blocked config falls here as plain mmio
      c = DSP_HUB_ABORT; // RL10 RL14
      for (int w = NWIN - 1; w >= 0; w--) begin
        if (win_hit[w]) begin
          c = DSP_PCIE; // RL9
          p = win_port[w];
        end
      end
    end
    // RL13
    if (c == DSP_HUB_ABORT && req_from_hub_in && ctrl[CTL_LOCAL_ABORT]) begin
      c = DSP_LOCAL_ABORT;
    end
    if (req_valid_in) begin
      ev[ST_HUB_ABORT] = (c == DSP_HUB_ABORT);
      ev[ST_LOCAL_ABORT] = (c == DSP_LOCAL_ABORT);
      ev[ST_CFG_BLOCKED] = in_cfg && ctrl[CTL_CFG_BLOCK] && (req_addr_in >= HOLE_END);
      ev[ST_SUBTRACTIVE] = (c == DSP_HUB);
    end
    next_d_valid = req_valid_in; // RL16
    next_d_code = req_valid_in ? c : d_code;
    next_d_addr = req_valid_in ? req_addr_in : d_addr; // RL12
    next_d_port = req_valid_in ? p : d_port;
  end

  // disposition flops: issue one cycle after the request
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      d_valid <= 1'b0;
      d_code <= DSP_HUB;
      d_addr <= '0;
      d_port <= '0;
    end else begin
      d_valid <= next_d_valid;
      d_code <= next_d_code;
      d_addr <= next_d_addr;
      d_port <= next_d_port;
    end
  end

  assign disp_valid_out = d_valid;
  assign disp_code_out = d_code;
  assign disp_addr_out = d_addr;
  assign disp_port_out = d_port;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_req(logic [ADDR_W-1:0] lo, logic [ADDR_W-1:0] hi);
    req_valid_in && req_addr_in >= lo && req_addr_in < hi;
  endsequence
  sequence s_issue(iad_disp_t code);
    disp_valid_out && disp_code_out == code;
  endsequence

  a_dos_coherent: assert property ( // RL1
    s_req(40'h00_0000_0000, DOS_END) |=> s_issue(DSP_MEM_COH))
    else $error("dos access not coherent");
  a_video_off_abort: assert property ( // RL2
    s_req(DOS_END, VGA_END) && !ctrl[CTL_SMM_EN] && !ctrl[CTL_VGA_EN] && !req_from_hub_in
    |=> s_issue(DSP_HUB_ABORT))
    else $error("video range not aborted");
  a_video_smm_abort: assert property ( // RL3
    s_req(DOS_END, VGA_END) && ctrl[CTL_SMM_EN] && !ctrl[CTL_VGA_SMM_SEL]
    |=> disp_code_out inside {DSP_HUB_ABORT, DSP_LOCAL_ABORT})
    else $error("smm video range not aborted");
  a_video_nc: assert property ( // RL4
    s_req(DOS_END, VGA_END) && ctrl[CTL_VGA_EN] && !ctrl[CTL_SMM_EN]
    |=> disp_code_out == (($past(ctrl[CTL_VGA_TO_PCIE])) ? DSP_PCIE : DSP_HUB))
    else $error("video request misrouted");
  a_bios_nc: assert property ( // RL5
    s_req(VGA_END, BIOS_END) && ctrl[CTL_BIOS_HI:CTL_BIOS_LO] == BIOS_ATTR_RW
    |=> s_issue(DSP_MEM_NC))
    else $error("bios segment not non-coherent");
  a_isa_hole: assert property ( // RL6
    s_req(LOWMED_END, HOLE_END)
    |=> disp_code_out == ($past(ctrl[CTL_HOLE_EN]) ? DSP_HUB : DSP_MEM_COH))
    else $error("isa hole misrouted");
  a_addr_kept: assert property ( // RL12
    req_valid_in |=> disp_valid_out && disp_addr_out == $past(req_addr_in))
    else $error("forwarded address altered");
  a_cfg_block: assert property ( // RL11
    disp_valid_out && disp_code_out == DSP_CFG |-> !$past(ctrl[CTL_CFG_BLOCK]))
    else $error("config access passed while blocked");
  a_local_abort: assert property ( // RL13
    disp_valid_out && disp_code_out == DSP_LOCAL_ABORT
    |-> $past(req_from_hub_in) && $past(ctrl[CTL_LOCAL_ABORT]))
    else $error("local abort without hub origin");
  a_one_issue: assert property ( // RL16
    !req_valid_in |=> !disp_valid_out)
    else $error("disposition issued without request");
  a_event_sticky: assert property (
    ev != '0 |=> (stat & $past(ev)) == $past(ev))
    else $error("status event not latched");
  a_bus_answer: assert property (
    acc && avs_waitrequest_out |=> !avs_waitrequest_out || !acc)
    else $error("bus answer late");
endmodule
`default_nettype wire

/* iad_pkg.sv */
// constants, register map and disposition codes of the inbound address router
// assumes a 40-bit inbound address and 1 MB granules for programmable bounds
package iad_pkg;
  localparam int ADDR_W = 40;
  localparam int MB_W = 20;
  localparam int MB_LSB = 20;
  localparam int NWIN = 2;
  localparam int PORT_W = 4;
  // fixed range ends, each exclusive
  localparam logic [ADDR_W-1:0] DOS_END = 40'h00_000a_0000;
  localparam logic [ADDR_W-1:0] VGA_END = 40'h00_000c_0000;
  localparam logic [ADDR_W-1:0] BIOS_END = 40'h00_0010_0000;
  localparam logic [ADDR_W-1:0] LOWMED_END = 40'h00_00f0_0000;
  localparam logic [ADDR_W-1:0] HOLE_END = 40'h00_0100_0000;
  localparam logic [ADDR_W-1:0] MMIO_END = 40'h00_fe00_0000;
  localparam logic [MB_W-1:0] CFG_WIN_MB = 20'h00100;
  localparam logic [1:0] BIOS_ATTR_RW = 2'h3;
  // register word indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TOP_OF_LOW_MEMORY = 4'h1;
  localparam logic [3:0] REG_TOP_SMRAM_SEGMENT = 4'h2;
  localparam logic [3:0] REG_ESMM = 4'h3;
  localparam logic [3:0] REG_CFGB = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h5;
  localparam logic [3:0] REG_MASK = 4'h6;
  localparam logic [3:0] REG_CNT = 4'h7;
  localparam logic [3:0] REG_WIN = 4'h8;
  // control bits
  localparam int CTL_VGA_EN = 0;
  localparam int CTL_VGA_SMM_SEL = 1;
  localparam int CTL_SMM_EN = 2;
  localparam int CTL_TOP_SMRAM_SEGMENT_EN = 3;
  localparam int CTL_HOLE_EN = 4;
  localparam int CTL_CFG_BLOCK = 5;
  localparam int CTL_LOCAL_ABORT = 6;
  localparam int CTL_VGA_TO_PCIE = 7;
  localparam int CTL_BIOS_LO = 8;
  localparam int CTL_BIOS_HI = 9;
  localparam int CTL_VGA_PORT_LO = 12;
  localparam int CTL_VGA_PORT_HI = 15;
  // window base register fields
  localparam int WIN_PORT_LO = 24;
  localparam int WIN_PORT_HI = 27;
  localparam int WIN_EN_BIT = 31;
  // status bits
  localparam int ST_HUB_ABORT = 0;
  localparam int ST_LOCAL_ABORT = 1;
  localparam int ST_CFG_BLOCKED = 2;
  localparam int ST_SUBTRACTIVE = 3;
  localparam int ST_W = 4;
  // values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TOP_OF_LOW_MEMORY_RST = 32'h0000_0800;
  localparam logic [31:0] TOP_SMRAM_SEGMENT_RST = 32'h0000_0001;
  localparam logic [31:0] ESMM_RST = 32'h0000_0800;
  localparam logic [31:0] CFGB_RST = 32'h0000_0e00;
  localparam logic [31:0] WIN_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    DSP_MEM_COH = 3'h0,
    DSP_MEM_NC = 3'h1,
    DSP_PCIE = 3'h2,
    DSP_HUB = 3'h3,
    DSP_HUB_ABORT = 3'h4,
    DSP_LOCAL_ABORT = 3'h5,
    DSP_CFG = 3'h6
  } iad_disp_t;
endpackage

/* iad_window_match.sv */
// one base/limit window compare of the inbound router
// assumes base and limit in 1 MB granules, limit inclusive
`timescale 1ns/1ps
`default_nettype none
module iad_window_match (
  input wire logic [iad_pkg::MB_W-1:0] mb_in,
  input wire logic [31:0] base_in,
  input wire logic [31:0] limit_in,
  output logic hit_out,
  output logic [iad_pkg::PORT_W-1:0] port_out
);
  import iad_pkg::*;
  logic legal;
  // a window with base above limit is never legal, so it cannot claim
  assign legal = base_in[WIN_EN_BIT] && (base_in[MB_W-1:0] <= limit_in[MB_W-1:0]);
  assign hit_out = legal && (mb_in >= base_in[MB_W-1:0]) && (mb_in <= limit_in[MB_W-1:0]);
  assign port_out = base_in[WIN_PORT_HI:WIN_PORT_LO];
endmodule
`default_nettype wire

/* iad_far_sink.sv */
// far-end model of the router's targets: memory, pcie ports and hub link
// assumes one clock with the router and targets that never stall
`timescale 1ns/1ps
`default_nettype none
module iad_far_sink (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic disp_valid_in,
  output logic [15:0] taken_out
);
  logic [15:0] next_taken;
  // every pulse is one delivered request; no back-pressure, as on the real links
  always_comb begin
    next_taken = taken_out;
    if (disp_valid_in) begin
      next_taken = taken_out + 16'h0001;
    end
  end
  // tally register
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      taken_out <= 16'h0000;
    end else begin
      taken_out <= next_taken;
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench of the inbound address router
// assumes iad_pkg and the far sink model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iad_pkg::*;
  typedef struct {iad_disp_t code; logic [ADDR_W-1:0] addr; logic [PORT_W-1:0] port;} iad_exp_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic req_v = 1'b0;
  logic [ADDR_W-1:0] req_a = '0;
  logic req_hub = 1'b0;
  logic [31:0] rdat;
  logic wait_req;
  logic irq;
  logic dv;
  iad_disp_t dcode;
  logic [ADDR_W-1:0] daddr;
  logic [PORT_W-1:0] dport;
  logic [15:0] taken;
  logic [15:0] lfsr = 16'h4b6b;
  logic [31:0] cur = 32'h0;
  int num_errors = 0;
  int num_checks = 0;
  int num_sent = 0;
  iad_exp_t dq[$];
  logic [31:0] rq[$];
  iad_router i_dut (.clk_sys_in(clk), .rstn_in(rstn), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_req), .irq_out(irq),
    .req_valid_in(req_v), .req_addr_in(req_a), .req_from_hub_in(req_hub),
    .disp_valid_out(dv), .disp_code_out(dcode), .disp_addr_out(daddr), .disp_port_out(dport));
  iad_far_sink i_sink (.clk_sys_in(clk), .rstn_in(rstn), .disp_valid_in(dv), .taken_out(taken));
  // 25 mhz
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // outputs compared mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    iad_exp_t e;
    if (dv === 1'b1) begin
      if (dq.size() == 0) begin
        check("extra disposition", 64'h0, 64'h1);
      end else begin
        e = dq.pop_front();
        check("disp_code", 64'(e.code), 64'(dcode));
        check("disp_addr", 64'(e.addr), 64'(daddr));
        if (e.code == DSP_PCIE) begin
          check("disp_port", 64'(e.port), 64'(dport));
        end
      end
    end
    if (rd === 1'b1 && wait_req === 1'b0) begin
      check("readdata", 64'(rq.pop_front()), 64'(rdat));
    end
  end
  // bounded wait for the slave's answer, then the edge that samples it
  task automatic wait_ack;
    int n;
    n = 0;
    @(negedge clk);
    while (wait_req !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      check("waitrequest", 64'h0, 64'h1);
      stop_test();
    end
    @(posedge clk);
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    be <= b;
    wr <= 1'b1;
    wait_ack();
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    rq.push_back(exp);
    wait_ack();
    rd <= 1'b0;
  endtask
  task automatic send(input logic [ADDR_W-1:0] a, input logic h, input iad_disp_t c,
                      input logic [PORT_W-1:0] p);
    @(posedge clk);
    req_v <= 1'b1;
    req_a <= a;
    req_hub <= h;
    dq.push_back('{c, a, p});
    num_sent++;
  endtask
  task automatic idle;
    @(posedge clk);
    req_v <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // rows with the same control value go out back to back
  task automatic row(input logic [31:0] v, input logic [ADDR_W-1:0] a, input logic h,
                     input iad_disp_t c, input logic [PORT_W-1:0] p);
    if (v != cur) begin
      idle();
      bus_wr(4'h0, v, 4'hf);
      cur = v;
    end
    send(a, h, c, p);
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    logic [31:0] rst_val [9];
    rst_val = '{CTRL_RST, TOP_OF_LOW_MEMORY_RST, TOP_SMRAM_SEGMENT_RST, ESMM_RST, CFGB_RST, 32'h0, 32'h0, 32'h0, WIN_RST};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      bus_rd(4'(i), rst_val[i]);
    end
    bus_wr(4'hc, 32'hffff_ffff, 4'hf);
    bus_rd(4'hc, 32'h0);
    bus_wr(4'h7, 32'h0000_1234, 4'hf);
    bus_rd(4'h7, 32'h0);
    bus_wr(4'h1, 32'hffff_ffff, 4'h1);
    bus_rd(4'h1, 32'h0000_08ff);
    bus_wr(4'h1, 32'h0000_0800, 4'hf);
    // window 0 port 3 at 0x900-0x90f mb, window 1 port 2 at 0xa00 mb
    bus_wr(4'h8, 32'h8300_0900, 4'hf);
    bus_wr(4'h9, 32'h0000_090f, 4'hf);
    bus_wr(4'ha, 32'h8200_0a00, 4'hf);
    bus_wr(4'hb, 32'h0000_0a00, 4'hf);
    row(32'h0, 40'h0, 1'b0, DSP_MEM_COH, 4'h0);
    row(32'h0, 40'h9_ffff, 1'b1, DSP_MEM_COH, 4'h0);
    row(32'h0, 40'h10_0000, 1'b0, DSP_MEM_COH, 4'h0);
    row(32'h0, 40'hef_ffff, 1'b0, DSP_MEM_COH, 4'h0);
    row(32'h0, 40'ha_0000, 1'b0, DSP_HUB_ABORT, 4'h0);
    row(32'h0, 40'hc_0000, 1'b0, DSP_HUB, 4'h0);
    row(32'h0, 40'hf0_0000, 1'b0, DSP_MEM_COH, 4'h0);
    row(32'h0, 40'h100_0000, 1'b0, DSP_MEM_COH, 4'h0);
    row(32'h0, 40'h7fef_ffff, 1'b0, DSP_MEM_COH, 4'h0);
    row(32'h0, 40'h7ff0_0000, 1'b0, DSP_MEM_COH, 4'h0);
    row(32'h0, 40'he000_0000, 1'b0, DSP_CFG, 4'h0);
    row(32'h0, 40'hefff_ffff, 1'b0, DSP_CFG, 4'h0);
    row(32'h0, 40'hf000_0000, 1'b0, DSP_HUB_ABORT, 4'h0);
    row(32'h0, 40'hfdff_ffff, 1'b0, DSP_HUB_ABORT, 4'h0);
    row(32'h0, 40'h8000_0000, 1'b0, DSP_HUB_ABORT, 4'h0);
    row(32'h0, 40'hfe00_0000, 1'b0, DSP_HUB, 4'h0);
    row(32'h0, 40'hff_0000_0000, 1'b0, DSP_HUB, 4'h0);
    row(32'h0, 40'h9000_0000, 1'b0, DSP_PCIE, 4'h3);
    row(32'h0, 40'h90ff_ffff, 1'b0, DSP_PCIE, 4'h3);
    row(32'h0, 40'h9100_0000, 1'b0, DSP_HUB_ABORT, 4'h0);
    row(32'h0, 40'ha00f_ffff, 1'b0, DSP_PCIE, 4'h2);
    row(32'h5, 40'hb_ffff, 1'b0, DSP_HUB_ABORT, 4'h0);
    row(32'h5081, 40'ha_0000, 1'b0, DSP_PCIE, 4'h5);
    row(32'h1, 40'hb_ffff, 1'b0, DSP_HUB, 4'h0);
    row(32'h87, 40'hb_0000, 1'b0, DSP_PCIE, 4'h0);
    row(32'h6, 40'ha_0000, 1'b0, DSP_HUB_ABORT, 4'h0);
    row(32'h300, 40'hc_0000, 1'b0, DSP_MEM_NC, 4'h0);
    row(32'h300, 40'hf_ffff, 1'b0, DSP_MEM_NC, 4'h0);
    row(32'h10, 40'hff_ffff, 1'b0, DSP_HUB, 4'h0);
    row(32'hc, 40'h7ff0_0000, 1'b0, DSP_HUB_ABORT, 4'h0);
    row(32'hc, 40'h7fff_ffff, 1'b0, DSP_HUB_ABORT, 4'h0);
    row(32'h20, 40'he000_0000, 1'b0, DSP_HUB_ABORT, 4'h0);
    row(32'h40, 40'ha_0000, 1'b1, DSP_LOCAL_ABORT, 4'h0);
    row(32'h40, 40'ha_0000, 1'b0, DSP_HUB_ABORT, 4'h0);
    // random back-to-back traffic in the low legacy range
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      row(32'h0, {21'h0, lfsr[2:0], lfsr}, lfsr[5], DSP_MEM_COH, 4'h0);
    end
    idle();
    // interrupt: masked event, unmask, write-one clear
    bus_wr(4'h5, 32'h0000_000f, 4'hf);
    bus_wr(4'h6, 32'h0, 4'hf);
    row(32'h0, 40'ha_0000, 1'b0, DSP_HUB_ABORT, 4'h0);
    idle();
    @(negedge clk);
    check("irq masked", 64'h0, 64'(irq));
    bus_rd(4'h5, 32'h0000_0001);
    bus_wr(4'h6, 32'h0000_0001, 4'hf);
    @(negedge clk);
    check("irq raised", 64'h1, 64'(irq));
    bus_wr(4'h5, 32'h0000_0001, 4'hf);
    @(negedge clk);
    check("irq cleared", 64'h0, 64'(irq));
    bus_rd(4'h5, 32'h0);
    bus_rd(4'h7, 32'(num_sent));
    check("delivered", 64'(num_sent), 64'(taken));
    check("pending", 64'h0, 64'(dq.size()));
    stop_test();
  end
endmodule
`default_nettype wire
